/* mps_stepper.sv */
// Top: motor-operated potentiometer reference stepper with APB registers
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module mps_stepper #(
   parameter int unsigned REF_W = mps_pkg::REF_W,
   parameter int unsigned NUM_CHAN = mps_pkg::NUM_CHAN
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic pot_up_input_i,
   input wire logic pot_down_input_i,
   input wire logic key_up_i,
   input wire logic key_down_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic [REF_W-1:0] motor_pot_value_o,
   output logic [NUM_CHAN-1:0] chan_select_o,
   output logic [NUM_CHAN*REF_W-1:0] chan_ref_o
);

   // ==========================================================
   // Input synchronisers (pins are asynchronous)
   logic [3:0] sync1_q, sync1_d; // First stage, read only by second
   logic [3:0] sync2_q, sync2_d; // Second stage
   logic up_any;
   logic down_any;

   always_comb begin
      sync1_d = {key_down_i, key_up_i, pot_down_input_i, pot_up_input_i};
      sync2_d = sync1_q;
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else if (clk_en_i) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   assign up_any = sync2_q[0] | sync2_q[2];
   assign down_any = sync2_q[1] | sync2_q[3];

   // ==========================================================
   // Registers
   logic [1:0] mode_q, mode_d;                 // pot_mode_select
   logic [15:0] div_q, div_d;                  // Update period minus one
   logic [REF_W-1:0] step_q, step_d;           // pot_step_size
   logic [NUM_CHAN*4-1:0] src_q, src_d;        // channel_source_selector fields
   logic [REF_W-1:0] value_q, value_d;         // Stored reference
   logic [15:0] tick_cnt_q, tick_cnt_d;        // Update period counter
   logic [31:0] prdata_q, prdata_d;            // Read data
   logic tick;
   logic wr_acc;
   logic rd_acc;
   mps_pkg::mps_req_t req;
   mps_pkg::mps_act_t act;

   // Slave answers in the access cycle, no wait states
   assign pready_o = 1'b1;
   assign wr_acc = psel_i && penable_i && pwrite_i;
   assign rd_acc = psel_i && !penable_i && !pwrite_i;
   assign prdata_o = prdata_q;

   // Address decode helper used only by the error response
   function automatic logic addr_hit(input logic [7:0] a);
      return (a == mps_pkg::ADDR_CTRL) || (a == mps_pkg::ADDR_STEP) ||
             (a == mps_pkg::ADDR_SRC) || (a == mps_pkg::ADDR_VALUE) ||
             (a == mps_pkg::ADDR_STATUS);
   endfunction

   // Unmapped addresses answer with an error
   assign pslverr_o = psel_i && penable_i && !addr_hit(paddr_i);

   // ==========================================================
   // Update period tick for level modes
   always_comb begin
      // A shortened period restarts at once instead of running the counter round
      tick = (tick_cnt_q >= div_q);
      tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
   end

   // ==========================================================
   // Trigger decode
   mps_trigger u_trig (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .up_i(up_any),
      .down_i(down_any),
      .mode_i(mode_q),
      .tick_i(tick),
      .req_o(req)
   );

   // Pick the action; clear has priority
   always_comb begin
      if (req.clear) begin
         act = mps_pkg::MPS_CLR;
      end else if (req.up) begin
         act = mps_pkg::MPS_INC;
      end else if (req.down) begin
         act = mps_pkg::MPS_DEC;
      end else begin
         act = mps_pkg::MPS_HOLD;
      end
   end

   // ==========================================================
   // Value update; wraps modulo width, software limits range
   always_comb begin
      case (act)
         mps_pkg::MPS_CLR: begin
            value_d = '0;
         end
         mps_pkg::MPS_INC: begin
            value_d = value_q + step_q;
         end
         mps_pkg::MPS_DEC: begin
            value_d = value_q - step_q;
         end
         mps_pkg::MPS_HOLD: begin
            value_d = value_q;
         end
         default: begin
            value_d = value_q;
         end
      endcase
   end

   // ==========================================================
   // Register writes, taken in the access cycle
   always_comb begin
      mode_d = mode_q;
      div_d = div_q;
      step_d = step_q;
      src_d = src_q;
      if (wr_acc) begin
         case (paddr_i)
            mps_pkg::ADDR_CTRL: begin
               mode_d = pwdata_i[mps_pkg::CTRL_MODE_LSB +: 2];
               div_d = pwdata_i[mps_pkg::CTRL_DIV_LSB +: 16];
            end
            mps_pkg::ADDR_STEP: begin
               step_d = pwdata_i[REF_W-1:0];
            end
            mps_pkg::ADDR_SRC: begin
               src_d = pwdata_i[NUM_CHAN*4-1:0];
            end
            default: begin
               mode_d = mode_q;
            end
         endcase
      end
   end

   // Read data captured in setup, stable through access
   always_comb begin
      prdata_d = prdata_q;
      if (rd_acc) begin
         case (paddr_i)
            mps_pkg::ADDR_CTRL: begin
               prdata_d = {div_q, 14'h0000, mode_q};
            end
            mps_pkg::ADDR_STEP: begin
               prdata_d = 32'(step_q);
            end
            mps_pkg::ADDR_SRC: begin
               prdata_d = 32'(src_q);
            end
            mps_pkg::ADDR_VALUE: begin
               prdata_d = 32'(value_q);
            end
            mps_pkg::ADDR_STATUS: begin
               prdata_d = {28'h0000000, sync2_q};
            end
            default: begin
               prdata_d = 32'h00000000;
            end
         endcase
      end
   end

   // Register all state; clock enable freezes everything
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mode_q <= mps_pkg::MODE_RST;
         div_q <= mps_pkg::DIV_RST;
         step_q <= REF_W'(mps_pkg::STEP_RST);
         src_q <= (NUM_CHAN*4)'(mps_pkg::SRC_RST);
         value_q <= REF_W'(mps_pkg::VALUE_RST);
         tick_cnt_q <= 16'h0000;
         prdata_q <= 32'h00000000;
      end else if (clk_en_i) begin
         mode_q <= mode_d;
         div_q <= div_d;
         step_q <= step_d;
         src_q <= src_d;
         value_q <= value_d;
         tick_cnt_q <= tick_cnt_d;
         prdata_q <= prdata_d;
      end
   end

   // ==========================================================
   // Channel outputs
   assign motor_pot_value_o = value_q;

   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         chan_select_o[i] = (src_q[i*4 +: 4] == mps_pkg::SRC_MOTOR_POT);
         chan_ref_o[i*REF_W +: REF_W] = chan_select_o[i] ? value_q : '0;
      end
   end

endmodule // mps_stepper

/* mps_pkg.sv */
// Package: constants and types for the motor-operated potentiometer reference stepper
package mps_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned REF_W = 16;
   localparam int unsigned NUM_CHAN = 4;
   localparam int unsigned SRC_W = 4;

   // ==========================================================
   // APB register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;   // Mode and update divider
   localparam logic [7:0] ADDR_STEP = 8'h04;   // Step size
   localparam logic [7:0] ADDR_SRC = 8'h08;    // Channel source selectors
   localparam logic [7:0] ADDR_VALUE = 8'h0c;  // Stored value (read only)
   localparam logic [7:0] ADDR_STATUS = 8'h10; // Synchronised input levels (read only)

   // ==========================================================
   // Field positions and reset values
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_DIV_LSB = 16;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [15:0] STEP_RST = 16'h0001;
   localparam logic [15:0] DIV_RST = 16'h0000;
   localparam logic [15:0] SRC_RST = 16'h0000;
   localparam logic [15:0] VALUE_RST = 16'h0000;

   // Source code that picks the stepper for a channel
   localparam logic [3:0] SRC_MOTOR_POT = 4'h1;

   // Mode bits: bit 0 clear enable, bit 1 edge triggering
   localparam int unsigned MODE_CLR_BIT = 0;
   localparam int unsigned MODE_EDGE_BIT = 1;

   // Request carrier from the trigger logic
   typedef struct packed {
      logic up;
      logic down;
      logic clear;
   } mps_req_t;

   // Step decision
   typedef enum logic [3:0] {
      MPS_HOLD = 4'b0001,
      MPS_INC = 4'b0010,
      MPS_DEC = 4'b0100,
      MPS_CLR = 4'b1000
   } mps_act_t;

endpackage

/* mps_trigger.sv */
// Trigger logic: turns up/down levels into step requests per mode
`timescale 1ns/1ps
module mps_trigger (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic up_i,
   input wire logic down_i,
   input wire logic [1:0] mode_i,
   input wire logic tick_i,
   output mps_pkg::mps_req_t req_o
);

   // ==========================================================
   // Edge history
   logic up_prev_q, up_prev_d;     // Last up level
   logic down_prev_q, down_prev_d; // Last down level
   logic edge_mode;
   logic clr_mode;

   assign edge_mode = mode_i[mps_pkg::MODE_EDGE_BIT];
   assign clr_mode = mode_i[mps_pkg::MODE_CLR_BIT];

   // Next history and request decode
   always_comb begin
      up_prev_d = up_i;
      down_prev_d = down_i;
      req_o = '{up: 1'b0, down: 1'b0, clear: 1'b0};
      if (clr_mode && up_i && down_i) begin
         req_o.clear = 1'b1;
      end else if (edge_mode) begin
         req_o.up = up_i && !up_prev_q && !down_i;
         req_o.down = down_i && !down_prev_q && !up_i;
      end else begin
         req_o.up = tick_i && up_i && !down_i;
         req_o.down = tick_i && down_i && !up_i;
      end
   end

   // Register history; frozen with clock enable
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         up_prev_q <= 1'b0;
         down_prev_q <= 1'b0;
      end else if (clk_en_i) begin
         up_prev_q <= up_prev_d;
         down_prev_q <= down_prev_d;
      end
   end

endmodule // mps_trigger

/* mps_chk.sv */
// Checker: port-level properties of the reference stepper
`timescale 1ns/1ps
module mps_chk #(
   parameter int unsigned REF_W = 16,
   parameter int unsigned NUM_CHAN = 4
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic pot_up_input_i,
   input wire logic pot_down_input_i,
   input wire logic key_up_i,
   input wire logic key_down_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [REF_W-1:0] motor_pot_value_o,
   input wire logic [NUM_CHAN-1:0] chan_select_o,
   input wire logic [NUM_CHAN*REF_W-1:0] chan_ref_o
);
   // ==========================================================
   // Shadow registers, rebuilt from APB writes
   logic [15:0] step_q, div_q, src_q, gap_q, held_q;
   logic [REF_W-1:0] prev_q;
   logic [1:0] mode_q;
   logic up, dn, sel_ok, ref_ok;
   // Pins and keys are merged, as the design does
   assign up = pot_up_input_i | key_up_i;
   assign dn = pot_down_input_i | key_down_i;
   // Per channel decode and routing
   always_comb begin
      sel_ok = 1'b1;
      ref_ok = 1'b1;
      for (int i = 0; i < NUM_CHAN; i++) begin
         sel_ok &= chan_select_o[i] == (src_q[4*i+:4] == 4'h1);
         ref_ok &= chan_ref_o[REF_W*i+:REF_W] == (chan_select_o[i] ? motor_pot_value_o : '0);
      end
   end
   // Gap counts cycles between value changes; held counts a steady lone up request
   always_ff @(posedge sys_clk_i) begin
      prev_q <= motor_pot_value_o;
      gap_q <= (motor_pot_value_o != prev_q) ? 16'h1 : gap_q + 16'(gap_q != 16'hffff);
      held_q <= (up && !dn) ? held_q + 16'(held_q != 16'hffff) : 16'h0;
      if (reset_i) begin
         mode_q <= 2'h0;
         step_q <= 16'h1;
         div_q <= 16'h0;
         src_q <= 16'h0;
      end else if (psel_i && penable_i && pwrite_i && clk_en_i) begin
         if (paddr_i == mps_pkg::ADDR_CTRL) begin
            mode_q <= pwdata_i[1:0];
            div_q <= pwdata_i[31:16];
         end
         if (paddr_i == mps_pkg::ADDR_STEP) step_q <= pwdata_i[15:0];
         if (paddr_i == mps_pkg::ADDR_SRC) src_q <= pwdata_i[15:0];
      end
   end
   // ==========================================================
   // Properties; settle windows cover the two-stage input sync
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   property p_sel; sel_ok; endproperty
   a_sel: assert property (p_sel) else $error("select decode wrong");
   property p_ref; $stable(motor_pot_value_o) && $stable(chan_select_o) |-> ref_ok; endproperty
   a_ref: assert property (p_ref) else $error("channel value wrong");
   property p_step; motor_pot_value_o != prev_q |-> motor_pot_value_o == '0 ||
      motor_pot_value_o - prev_q == step_q[REF_W-1:0] || prev_q - motor_pot_value_o == step_q[REF_W-1:0]; endproperty
   a_step: assert property (p_step) else $error("change not one step");
   property p_hold; (!up && !dn)[*6] |-> $stable(motor_pot_value_o); endproperty
   a_hold: assert property (p_hold) else $error("value moved when idle");
   property p_clr; (mode_q[0] && up && dn)[*6] |-> motor_pot_value_o == '0; endproperty
   a_clr: assert property (p_clr) else $error("clear missed");
   property p_inc; (mode_q[1] && !up && !dn)[*5] ##1 (up && !dn)[*6] |->
      motor_pot_value_o - $past(motor_pot_value_o, 6) == step_q[REF_W-1:0]; endproperty
   a_inc: assert property (p_inc) else $error("up edge not one step");
   property p_dec; (mode_q[1] && !up && !dn)[*5] ##1 (dn && !up)[*6] |->
      $past(motor_pot_value_o, 6) - motor_pot_value_o == step_q[REF_W-1:0]; endproperty
   a_dec: assert property (p_dec) else $error("down edge not one step");
   property p_per; !mode_q[1] && held_q > div_q + 16'h8 && motor_pot_value_o != prev_q |-> gap_q == div_q + 16'h1;
   endproperty
   a_per: assert property (p_per) else $error("level period wrong");
endmodule // mps_chk

bind mps_stepper mps_chk #(.REF_W(REF_W), .NUM_CHAN(NUM_CHAN)) u_mps_chk (
   .sys_clk_i(sys_clk_i),
   .reset_i(reset_i),
   .clk_en_i(clk_en_i),
   .pot_up_input_i(pot_up_input_i),
   .pot_down_input_i(pot_down_input_i),
   .key_up_i(key_up_i),
   .key_down_i(key_down_i),
   .psel_i(psel_i),
   .penable_i(penable_i),
   .pwrite_i(pwrite_i),
   .paddr_i(paddr_i),
   .pwdata_i(pwdata_i),
   .motor_pot_value_o(motor_pot_value_o),
   .chan_select_o(chan_select_o),
   .chan_ref_o(chan_ref_o)
);

/* mps_far.sv */
// Partner: switches and panel keys on the far side
`timescale 1ns/1ps
module mps_far (
   input wire logic sys_clk_i,
   output logic [3:0] lines_o
);
   // Lines are {key_down, key_up, pin_down, pin_up}, all released at start
   initial lines_o = 4'h0;
   task automatic set(input logic [3:0] v);
      @(posedge sys_clk_i);
      lines_o <= v;
   endtask
endmodule // mps_far

/* testbench.sv */
// Testbench: self-checking run of the reference stepper
`timescale 1ns/1ps
module testbench;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic clk_en_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h0;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, r;
   logic pready_o, pslverr_o, e;
   logic [15:0] motor_pot_value_o;
   logic [3:0] chan_select_o, lines;
   logic [63:0] chan_ref_o;
   logic [7:0] ra[5] = '{mps_pkg::ADDR_CTRL, mps_pkg::ADDR_STEP, mps_pkg::ADDR_SRC, mps_pkg::ADDR_VALUE, 8'h14};
   logic [32:0] rv[5] = '{33'h0, 33'h1, 33'h0, 33'h0, 33'h1_0000_0000};
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   int mdl = 0;
   int st, b, ok, dv, s;
   always #12.5 sys_clk_i = ~sys_clk_i;
   mps_far u_mps_far (.sys_clk_i(sys_clk_i), .lines_o(lines));
   mps_stepper u_mps_stepper (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .pot_up_input_i(lines[0]),
      .pot_down_input_i(lines[1]),
      .key_up_i(lines[2]),
      .key_down_i(lines[3]),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .prdata_o(prdata_o),
      .pready_o(pready_o),
      .pslverr_o(pslverr_o),
      .motor_pot_value_o(motor_pot_value_o),
      .chan_select_o(chan_select_o),
      .chan_ref_o(chan_ref_o)
   );
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [32:0] g, input logic [32:0] x);
      n_tests++;
      if (g !== x) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // Hold request lines for n cycles, then leave time for the sync stages
   task automatic pulse(input logic [3:0] v, input int n);
      u_mps_far.set(v);
      repeat (n) @(posedge sys_clk_i);
      u_mps_far.set(4'h0);
      repeat (8) @(posedge sys_clk_i);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      st = $urandom(32'h7a767f95);
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0);
         chk({e, r}, rv[i]);
      end
      apb(1'b1, mps_pkg::ADDR_VALUE, 32'h1234);
      apb(1'b0, mps_pkg::ADDR_VALUE, 32'h0);
      chk(r, mdl);
      $display("test registers done");
      for (int m = 2; m < 4; m++) begin
         st = 1 + $urandom % 16'hffff;
         apb(1'b1, mps_pkg::ADDR_CTRL, m);
         apb(1'b1, mps_pkg::ADDR_STEP, st);
         pulse(4'h3, 7);
         mdl = m[0] ? 0 : mdl;
         chk(motor_pot_value_o, mdl);
         repeat (6) begin
            s = $urandom % 4;
            pulse(4'h1 << s, 7);
            mdl = (s[0] ? mdl - st : mdl + st) & 16'hffff;
            chk(motor_pot_value_o, mdl);
         end
      end
      $display("test edge modes done");
      repeat (4) begin
         s = 0;
         for (int i = 0; i < 4; i++) s[4*i+:4] = $urandom % 3;
         apb(1'b1, mps_pkg::ADDR_SRC, s);
         apb(1'b0, mps_pkg::ADDR_SRC, 32'h0);
         chk(r, s);
         for (int i = 0; i < 4; i++) begin
            ok = s[4*i+:4] == 1;
            chk(chan_select_o[i], ok);
            chk(chan_ref_o[16*i+:16], ok ? mdl : 0);
         end
      end
      $display("test channels done");
      for (int m = 1; m >= 0; m--) begin
         dv = 3 + $urandom % 6;
         apb(1'b1, mps_pkg::ADDR_CTRL, (dv << 16) | m);
         for (int k = 0; k < 2; k++) begin
            b = motor_pot_value_o;
            pulse(k ? 4'h8 : 4'h1, 4 * (dv + 1));
            ok = 0;
            for (int j = 3; j < 6; j++) ok |= motor_pot_value_o == 16'(k ? b - j * st : b + j * st);
            chk(ok, 1);
         end
         b = m ? 0 : motor_pot_value_o;
         pulse(4'h3, 8);
         chk(motor_pot_value_o, b);
      end
      $display("test level modes done");
      // Clock enable low: no step and no register write may land
      b = motor_pot_value_o;
      clk_en_i <= 1'b0;
      pulse(4'h1, 6);
      apb(1'b1, mps_pkg::ADDR_STEP, st + 1);
      clk_en_i <= 1'b1;
      chk(motor_pot_value_o, b);
      apb(1'b0, mps_pkg::ADDR_STEP, 32'h0);
      chk(r, st);
      // Status shows the synchronised request lines
      s = $urandom % 16;
      u_mps_far.set(s);
      repeat (3) @(posedge sys_clk_i);
      apb(1'b0, mps_pkg::ADDR_STATUS, 32'h0);
      chk({e, r}, s);
      u_mps_far.set(4'h0);
      repeat (8) @(posedge sys_clk_i);
      $display("test enable and status done");
      conclude();
   end
endmodule // testbench
